// ### rtl/sram_pkg.sv
// Constants shared by the synchronous burst memory and its capture FIFO
package sram_pkg;
    localparam int ADDR_W = 15;              // External address width
    localparam int BYTES = 4;                // Data bytes per word
    localparam int BYTE_W = 8;               // Lines per data byte
    localparam int DATA_W = BYTES * BYTE_W;  // Data lines per word
    localparam int WORD_W = DATA_W + BYTES;  // Stored word with parity
    localparam int FIFO_DEPTH = 16;          // Capture FIFO entries
    localparam int BURST_W = 2;              // Burst counter width
    localparam logic [1:0] BURST_FIRST = 2'h0; // Counter value at a strobe
    localparam logic [1:0] BURST_STEP = 2'h1;  // Linear step per advance
    localparam logic [3:0] MASK_NONE = 4'h0;   // No byte shown
    localparam logic [3:0] MASK_ALL = 4'hf;    // All bytes shown
    localparam logic [31:0] DATA_RESET = 32'h0000_0000; // Output reset
    localparam logic [3:0] PARITY_RESET = 4'h0;         // Parity reset

    // Burst tracking, Gray coded
    typedef enum logic [1:0]
    {
        BURST_IDLE = 2'b00,
        BURST_RUN = 2'b01
    } burst_e;
endpackage

// ### rtl/capture_fifo.sv
// Parameterised FIFO with a registered output stage
`timescale 1ns/1ps
module capture_fifo
    import sram_pkg::*;
#(
    parameter int WIDTH = WORD_W,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];     // Queue storage
    logic [PW-1:0] wptr, next_wptr;      // Write pointer
    logic [PW-1:0] rptr, next_rptr;      // Read pointer
    logic [PW:0] count, next_count;      // Entries in storage
    logic next_out_valid;                // Output stage next valid
    logic next_in_ready;                 // Room for a word next cycle
    logic push, pop;                     // Storage moves

    // Full is honest: no push once every slot holds a word; ready is a
    // flop so the top-level output has no logic behind it
    always_comb
    begin
        push = in_valid_i & in_ready_o;
        pop = (count != '0) & (~out_valid_o | out_ready_i);
        next_wptr = push ? wptr + 1'b1 : wptr;
        next_rptr = pop ? rptr + 1'b1 : rptr;
        next_count = count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
        next_in_ready = (next_count != DEPTH[PW:0]);
        // Output stage empties only when the sink takes it
        if (pop)
            next_out_valid = 1'b1;
        else if (out_ready_i)
            next_out_valid = 1'b0;
        else
            next_out_valid = out_valid_o;
    end

    // Pointer and flag registers
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
            in_ready_o <= 1'b1;
            out_valid_o <= 1'b0;
            out_data_o <= '0;
        end
        else
        begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            count <= next_count;
            in_ready_o <= next_in_ready;
            out_valid_o <= next_out_valid;
            if (pop)
                out_data_o <= store[rptr];
        end
    end

    // Storage has no reset; only written slots are ever read
    always_ff @(posedge clock_i)
    begin
        if (push)
            store[wptr] <= in_data_i;
    end
endmodule

// ### rtl/sync_burst_sram.sv
// Pipelined synchronous burst memory with byte parity and pass-through
//
// Overview of operation
// - Data lines form four upward-numbered bytes
// - One parity line belongs to each byte
// - Parity disable high leaves 32-bit operation
// - Parity enabled behaves like its byte
// - Read after write first shows written data
// - Idle after write shows data, no carryover
// - Single-byte write passes through that byte
// - First access registers full external address
// - Later accesses keep upper, derive low bits
// - Burst counter wraps after fourth access
// - Write registers address and data that cycle
// - Any byte write low tristates outputs
// - Controller strobe aborts burst, loads address
// - Written data reaches output register, OE gated
`timescale 1ns/1ps
module sync_burst_sram
    import sram_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [AW-1:0] address_lines_i,
    input wire logic [BYTES-1:0] byte_write_n_i,
    input wire logic chip_enable_n_i,
    input wire logic chip_enable2_i,
    input wire logic chip_enable2_n_i,
    input wire logic controller_addr_strobe_n_i,
    input wire logic processor_addr_strobe_n_i,
    input wire logic burst_advance_n_i,
    input wire logic output_enable_n_i,
    input wire logic parity_disable_pin_i,
    input wire logic [DATA_W-1:0] data_lines_i,
    input wire logic [BYTES-1:0] parity_lines_i,
    output logic [DATA_W-1:0] data_lines_o,
    output logic [BYTES-1:0] data_lines_oe_o,
    output logic [BYTES-1:0] parity_lines_o,
    output logic [BYTES-1:0] parity_lines_oe_o,
    output logic capture_ready_o,
    output logic [WORD_W-1:0] capture_data_o,
    output logic capture_valid_o,
    input wire logic capture_ready_i
);
    // The array is written and read on the same clock; a read in the
    // cycle after a write sees the new word because the write lands on
    // the earlier edge
    logic [WORD_W-1:0] mem [2**AW];      // Core array, parity in top bits
    burst_e burst, next_burst;           // Burst in progress
    logic [AW-1:0] base_addr, next_base_addr; // Registered address
    logic [BURST_W-1:0] cnt, next_cnt;   // Burst offset
    logic [BYTES-1:0] show, next_show;   // Bytes the output may show
    logic [DATA_W-1:0] q_data, next_q_data;   // Output data register
    logic [BYTES-1:0] q_par, next_q_par;      // Output parity register
    logic par_off, next_par_off;         // Parity disable, registered
    logic cap_pend, next_cap_pend;       // Read word awaits capture
    logic proc_start, ctrl_start;        // Address strobes taken
    logic start, selected;               // New address, device enabled
    logic access, is_write, is_read;     // Present access kind
    logic [AW-1:0] use_addr;             // Address used this cycle
    logic [BYTES-1:0] wr_bytes;          // Bytes written this cycle
    logic [BURST_W-1:0] low_bits;        // Derived low address bits
    logic [WORD_W-1:0] rd_word;          // Array word at use_addr
    logic bus_free;                      // No byte write pin low, taken straight from the pins
    logic [BYTES-1:0] drive;             // Byte drivers enabled

    // Decode of strobes, enables and the address used this cycle
    always_comb
    begin
        // All three enables must be active for a strobe to start an access
        selected = ~chip_enable_n_i & chip_enable2_i & ~chip_enable2_n_i;
        // Processor strobe counts only while the low enable is active
        proc_start = ~processor_addr_strobe_n_i & ~chip_enable_n_i;
        ctrl_start = ~controller_addr_strobe_n_i;
        start = proc_start | ctrl_start;
        // Wrap comes free from the two-bit adder: no carry reaches the
        // upper address bits
        // Linear wrapping order from the registered low bits
        low_bits = base_addr[BURST_W-1:0] + cnt + BURST_STEP;
        if (start)
            use_addr = address_lines_i;
        else
            use_addr = {base_addr[AW-1:BURST_W], low_bits};
        // Enables matter only with a strobe; a running burst ignores them
        if (start)
            access = selected;
        else
            access = (burst == BURST_RUN) & ~burst_advance_n_i;
        // A processor strobe always reads, whatever the byte writes say
        is_write = access & ~proc_start & ~(&byte_write_n_i);
        is_read = access & ~is_write;
        // Unwritten lanes stay out of the pass-through mask
        wr_bytes = is_write ? ~byte_write_n_i : MASK_NONE;
        // Array read is combinational; the output register is the pipe
        rd_word = mem[use_addr];
    end

    // Next burst state, output register and byte-show mask
    always_comb
    begin
        next_burst = burst;
        next_base_addr = base_addr;
        next_cnt = cnt;
        next_show = show;
        next_q_data = q_data;
        next_q_par = q_par;
        next_par_off = parity_disable_pin_i;
        // Capture request trails each read by one cycle, when the output
        // register already holds the word
        next_cap_pend = is_read;
        if (start)
        begin
            // Strobe abandons any burst and takes the pins
            next_base_addr = address_lines_i;
            next_cnt = BURST_FIRST;
            next_burst = selected ? BURST_RUN : BURST_IDLE;
        end
        else if (access)
            next_cnt = cnt + BURST_STEP;
        if (is_write)
        begin
            // Written word goes straight to the output register
            next_q_data = data_lines_i;
            next_q_par = parity_lines_i;
            next_show = wr_bytes;
        end
        else if (is_read)
        begin
            next_q_data = rd_word[DATA_W-1:0];
            next_q_par = rd_word[WORD_W-1:DATA_W];
            next_show = MASK_ALL;
        end
        else if (start || burst != BURST_RUN)
            next_show = MASK_NONE;
        else
            // Burst wait states hold the word already on the outputs
            next_show = show;
    end

    // State registers
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            burst <= BURST_IDLE;
            base_addr <= '0;
            cnt <= BURST_FIRST;
            show <= MASK_NONE;
            q_data <= DATA_RESET;
            q_par <= PARITY_RESET;
            // Parity starts off so no parity driver turns on out of reset
            par_off <= 1'b1;
            cap_pend <= 1'b0;
        end
        else
        begin
            burst <= next_burst;
            base_addr <= next_base_addr;
            cnt <= next_cnt;
            show <= next_show;
            q_data <= next_q_data;
            q_par <= next_q_par;
            par_off <= next_par_off;
            cap_pend <= next_cap_pend;
        end
    end

    // Array write per byte lane; no reset on the core
    // Lanes whose byte write is high keep their old contents
    always_ff @(posedge clock_i)
    begin
        for (int b = 0; b < BYTES; b++)
        begin
            if (wr_bytes[b])
            begin
                mem[use_addr][b*BYTE_W +: BYTE_W] <=
                    data_lines_i[b*BYTE_W +: BYTE_W];
                // Stored parity frozen while parity is off
                if (!parity_disable_pin_i)
                    mem[use_addr][DATA_W+b] <= parity_lines_i[b];
            end
        end
    end

    // Output enable and byte writes act without the clock, as on the
    // real part; data itself always comes from the output register
    always_comb
    begin
        // A byte write on the pins turns every driver off at once, so the
        // controller can put write data on the lines in the same cycle
        bus_free = &byte_write_n_i;
        drive = show & {BYTES{~output_enable_n_i & bus_free}};
        data_lines_o = q_data;
        parity_lines_o = q_par;
        for (int b = 0; b < BYTES; b++)
            data_lines_oe_o[b] = drive[b];
        parity_lines_oe_o = drive & {BYTES{~par_off}};
    end

    // Each read word is copied to a stream; a full FIFO drops the copy
    // because the memory bus itself cannot be stalled
    // Ready low warns the sink that the next read copy will be lost;
    // the memory side never waits for it
    capture_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(DEPTH)
    ) u_capture (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .in_data_i({q_par, q_data}),
        .in_valid_i(cap_pend),
        .in_ready_o(capture_ready_o),
        .out_data_o(capture_data_o),
        .out_valid_o(capture_valid_o),
        .out_ready_i(capture_ready_i)
    );
endmodule

// ### tb/sync_burst_sram_sva.sv
// Concurrent checks on the memory pins and the capture stream
`timescale 1ns/1ps
module sync_burst_sram_sva
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [3:0] byte_write_n_i,
    input wire logic chip_enable_n_i,
    input wire logic chip_enable2_i,
    input wire logic chip_enable2_n_i,
    input wire logic controller_addr_strobe_n_i,
    input wire logic output_enable_n_i,
    input wire logic parity_disable_pin_i,
    input wire logic [31:0] data_lines_i,
    input wire logic [31:0] data_lines_o,
    input wire logic [3:0] data_lines_oe_o,
    input wire logic [3:0] parity_lines_oe_o,
    input wire logic [35:0] capture_data_o,
    input wire logic capture_valid_o,
    input wire logic capture_ready_i
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    // All three selects active
    wire sel = !chip_enable_n_i && chip_enable2_i && !chip_enable2_n_i;
    // Strobed write of any bytes, and of all bytes
    sequence wr_s;
        !controller_addr_strobe_n_i && sel && !(&byte_write_n_i);
    endsequence
    sequence wr_all_s;
        !controller_addr_strobe_n_i && sel && byte_write_n_i == 4'h0;
    endsequence
    // Strobe without select: no new cycle, burst ends
    sequence idle_s;
        !controller_addr_strobe_n_i && chip_enable_n_i && &byte_write_n_i;
    endsequence
    bw_tristate_a: assert property (!(&byte_write_n_i) |->
        data_lines_oe_o == 4'h0 && parity_lines_oe_o == 4'h0)
        else $error("drivers on during a byte write");
    oe_gate_a: assert property (output_enable_n_i |->
        data_lines_oe_o == 4'h0) else $error("drive without enable");
    parity_off_a: assert property ($past(parity_disable_pin_i) |->
        parity_lines_oe_o == 4'h0) else $error("parity driven when off");
    parity_follow_a: assert property (!$past(parity_disable_pin_i) |->
        parity_lines_oe_o == data_lines_oe_o) else $error("parity drive");
    pass_data_a: assert property (wr_all_s |=>
        data_lines_o == $past(data_lines_i)) else $error("no pass-through");
    pass_byte_a: assert property (wr_s ##1
        (!output_enable_n_i && &byte_write_n_i) |->
        data_lines_oe_o == ~$past(byte_write_n_i))
        else $error("wrong bytes shown after write");
    no_carry_a: assert property (wr_s ##1 idle_s |=>
        data_lines_oe_o == 4'h0) else $error("output carried over");
    cap_hold_a: assert property (capture_valid_o && !capture_ready_i |=>
        capture_valid_o && $stable(capture_data_o))
        else $error("capture word dropped while stalled");
endmodule
bind sync_burst_sram sync_burst_sram_sva sync_burst_sram_sva_i (.clock_i,
    .rstn_i, .byte_write_n_i, .chip_enable_n_i, .chip_enable2_i,
    .chip_enable2_n_i, .controller_addr_strobe_n_i, .output_enable_n_i,
    .parity_disable_pin_i, .data_lines_i, .data_lines_o, .data_lines_oe_o,
    .parity_lines_oe_o, .capture_data_o, .capture_valid_o, .capture_ready_i);

// ### tb/bus_master_model.sv
// Controller model that drives the memory bus one request at a time
`timescale 1ns/1ps
module bus_master_model
(
    output logic [14:0] addr_o,
    output logic [3:0] bw_n_o,
    output logic ce_n_o,
    output logic strobe_n_o,
    output logic proc_strobe_n_o,
    output logic step_n_o,
    output logic [31:0] data_o,
    output logic [3:0] par_o
);
    // Quiet bus at time zero: nothing strobed, nothing written
    initial
    begin
        {addr_o, ce_n_o, data_o, par_o} = '0;
        {bw_n_o, strobe_n_o, proc_strobe_n_o, step_n_o} = '1;
    end
    // Kinds: 0 strobe, 1 advance, 2 unselected strobe, 3 processor read,
    // 4 burst wait (no strobe, advance held high)
    // Called at a rising edge, so every change lands just after it
    task automatic cyc(int k, logic [14:0] a, logic [3:0] bw,
        logic [31:0] d, logic [3:0] p);
        // Junk address while stepping: the burst must not look at it
        addr_o <= (k == 1 || k == 4) ? ~a : a;
        bw_n_o <= bw;
        ce_n_o <= (k == 2);
        strobe_n_o <= !(k == 0 || k == 2);
        proc_strobe_n_o <= (k != 3);
        step_n_o <= (k != 1);
        // Released lines flip so a stale value never looks valid
        data_o <= (&bw) ? ~data_o : d;
        par_o <= (&bw) ? ~par_o : p;
    endtask
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the synchronous burst memory
`timescale 1ns/1ps
module tb_top
    import sram_pkg::*;
;
    logic clock_i, rstn_i, chip_enable2_i = 1'b1, chip_enable2_n_i = 1'b0;
    logic output_enable_n_i = 1'b0, parity_disable_pin_i = 1'b0;
    logic capture_ready_i = 1'b1, next_cap_rdy = 1'b1;
    logic next_oe_n = 1'b0, next_parity_disable_pin = 1'b0, pw = 1'b0, pchk = 1'b1;
    logic [14:0] address_lines_i, base;
    logic [3:0] byte_write_n_i, parity_lines_i, pmask = 4'h0;
    logic chip_enable_n_i, controller_addr_strobe_n_i, burst_advance_n_i;
    logic processor_addr_strobe_n_i, capture_ready_o, capture_valid_o;
    logic [31:0] data_lines_i, data_lines_o, seed = 32'h0000_e887, r;
    logic [3:0] data_lines_oe_o, parity_lines_o, parity_lines_oe_o;
    logic [35:0] capture_data_o, pend, mem [int], capq [$];
    int mismatches = 0;
    int total_checks = 0;
    sync_burst_sram sync_burst_sram_i (.clock_i, .rstn_i, .address_lines_i,
        .byte_write_n_i, .chip_enable_n_i, .chip_enable2_i, .chip_enable2_n_i,
        .controller_addr_strobe_n_i, .processor_addr_strobe_n_i,
        .burst_advance_n_i, .output_enable_n_i, .parity_disable_pin_i,
        .data_lines_i, .parity_lines_i, .data_lines_o, .data_lines_oe_o,
        .parity_lines_o, .parity_lines_oe_o, .capture_ready_o,
        .capture_data_o, .capture_valid_o, .capture_ready_i);
    bus_master_model bus_master_model_i (.addr_o(address_lines_i),
        .bw_n_o(byte_write_n_i), .ce_n_o(chip_enable_n_i),
        .strobe_n_o(controller_addr_strobe_n_i), .data_o(data_lines_i),
        .proc_strobe_n_o(processor_addr_strobe_n_i), .par_o(parity_lines_i),
        .step_n_o(burst_advance_n_i));
    initial
    begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    // Xorshift source, fixed seed so every run repeats
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Address of burst access n: upper bits kept, low pair counts up
    function automatic logic [14:0] baddr(logic [14:0] b, int n);
        return {b[14:2], b[1:0] + 2'(n)};
    endfunction
    task automatic chk(logic [35:0] got, logic [35:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One bus cycle; then check what the previous request left behind
    task automatic go(int k, logic [14:0] a, logic [3:0] bw, logic [35:0] w);
        logic [35:0] m;
        @(posedge clock_i);
        bus_master_model_i.cyc(k, a, bw, w[31:0], w[35:32]);
        output_enable_n_i <= next_oe_n;
        parity_disable_pin_i <= next_parity_disable_pin;
        capture_ready_i <= next_cap_rdy;
        #1;
        for (int b = 0; b < BYTES; b++)
        begin
            m[8*b +: 8] = {8{pmask[b]}};
            m[32+b] = pmask[b] & pchk;
        end
        if (pw)
            chk({parity_lines_o, data_lines_o} & m, pend & m);
        else
            chk({parity_lines_o, data_lines_o} & m, pend & m);
        // A burst wait leaves the output register and the mirror alone
        if (k == 4)
            return;
        pw = !(&bw) && k != 3;
        pchk = pw ? !next_parity_disable_pin : 1'b1;
        pmask = (k == 2) ? 4'h0 : (pw ? ~bw : 4'hf);
        pend = pw ? w : mem[a];
        // Mirror keeps only the enabled bytes; parity only when on
        for (int b = 0; b < BYTES && pw; b++)
            if (!bw[b])
            begin
                mem[a][8*b +: 8] = w[8*b +: 8];
                if (!next_parity_disable_pin)
                    mem[a][32+b] = w[32+b];
            end
        if (!pw && k != 2)
            capq.push_back(mem[a]);
    endtask
    // Every word the capture stream hands over, in read order
    always @(posedge clock_i)
        if (capture_valid_o === 1'b1 && capture_ready_i)
            chk(capture_data_o, capq.size() ? capq.pop_front() : 'x);
    initial
    begin
        rstn_i = 1'b0;
        repeat (5) @(posedge clock_i);
        rstn_i <= 1'b1;
        #1;
        chk({capture_ready_o, data_lines_oe_o}, 36'h0_0000_0010);
        r = rnd();
        base = {r[14:3], 3'h2};
        for (int i = 0; i < 8; i++)
            go(0, base + 15'(i), 4'h0, {r[7:4], rnd()});
        for (int n = 0; n < 5; n++) // Fifth access wraps onto the base
        begin
            go(n ? 1 : 0, baddr(base, n), 4'h0, {r[3:0], rnd()});
            if (n == 1)
                go(4, baddr(base, n), 4'hf, '0);
        end
        for (int n = 0; n < 6; n++)
        begin
            go(n ? 1 : 3, baddr(base, n), 4'hf, '0);
            if (n == 2)
                go(4, baddr(base, n), 4'hf, '0);
        end
        for (int i = 0; i < 60; i++)
        begin
            r = rnd();
            next_cap_rdy = r[4] | r[5];
            next_parity_disable_pin = r[13] & r[8] & !(&r[3:0]);
            go(r[8] ? 0 : 3, base + 15'(r[6:4]), r[8] ? r[3:0] : 4'hf,
                {r[19:16], rnd()});
        end
        next_parity_disable_pin = 1'b0;
        go(0, base, 4'hb, {4'h5, rnd()});
        go(2, base, 4'hf, '0);
        chk(data_lines_oe_o, 4'h4);
        go(0, base, 4'h0, {4'ha, rnd()});
        next_oe_n = 1'b1;
        go(2, base, 4'hf, '0);
        chk(data_lines_oe_o, 4'h0);
        next_oe_n = 1'b0;
        next_cap_rdy = 1'b1;
        for (int i = 0; i < 60 && capq.size() > 0; i++)
            go(2, base, 4'hf, '0);
        next_cap_rdy = 1'b0;
        for (int i = 0; i < 22; i++) // Stalled sink: fill until refused
            go(0, base + 15'(i % 8), 4'hf, '0);
        chk(capture_ready_o, 1'b0);
        next_cap_rdy = 1'b1;
        for (int i = 0; i < 30; i++)
            go(2, base, 4'hf, '0);
        capq.delete();
        end_of_test();
    end
    // Whole run is at most about two hundred cycles; this limit only catches a hang
    initial
    begin
        #500_000;
        mismatches++;
        end_of_test();
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
endmodule
